// >>> hw/left_effects_filter_coef_regs.sv
// Purpose: Left effects filter coefficient bank, registers 8 to 17 of page one
// Assumes: Control bus decoder presents byte writes and reads with a page bit
// Notes:   Pages other than one leave this bank untouched and read data zero
`timescale 1ns/100ps
`include "effects_coef_regs.svh"

// Behaviour
// - Byte pairs form signed 16-bit coefficients
// - Every byte reads back last written value
// - Reset numerator three low, numerator four
// - Reset numerator five bytes, low 5D
// - Reset denominator one high and low
// - Reset denominator two high and low
// - Reset denominator four high to 7D
// - Bank reachable only with page one
module left_effects_filter_coef_regs
    import effects_coef_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Control bus
    input  wire logic                      page_select,
    input  wire logic [`COEF_ADDR_W-1:0]   reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire coef_byte_t                reg_wdata,
    output coef_byte_t                     reg_rdata,
    output logic                           reg_hit,
    // Coefficients to the filter datapath
    output coef_word_t                     numerator_tap_three_low,
    output coef_word_t                     numerator_tap_four,
    output coef_word_t                     numerator_tap_five,
    output coef_word_t                     denominator_tap_one,
    output coef_word_t                     denominator_tap_two,
    output coef_byte_t                     denominator_tap_four_high
);
    localparam int NREG = 10;

    // Position of each register in the byte array, in offset order
    localparam int IDX_NUMER3_LOW  = 0;
    localparam int IDX_NUMER4_HIGH = 1;
    localparam int IDX_NUMER4_LOW  = 2;
    localparam int IDX_NUMER5_HIGH = 3;
    localparam int IDX_NUMER5_LOW  = 4;
    localparam int IDX_DENOM1_HIGH = 5;
    localparam int IDX_DENOM1_LOW  = 6;
    localparam int IDX_DENOM2_HIGH = 7;
    localparam int IDX_DENOM2_LOW  = 8;
    localparam int IDX_DENOM4_HIGH = 9;

    // Reset words of the committed coefficients, high byte on top
    localparam coef_word_t RST_WORD_NUMER4 = {`RST_NUMER4_HIGH, `RST_NUMER4_LOW};
    localparam coef_word_t RST_WORD_NUMER5 = {`RST_NUMER5_HIGH, `RST_NUMER5_LOW};
    localparam coef_word_t RST_WORD_DENOM1 = {`RST_DENOM1_HIGH, `RST_DENOM1_LOW};
    localparam coef_word_t RST_WORD_DENOM2 = {`RST_DENOM2_HIGH, `RST_DENOM2_LOW};

    logic [NREG-1:0] wr_sel;
    coef_byte_t      byte_val [NREG];
    logic            page_hit;
    logic            wr_hit;
    coef_word_t      tap3_low_next;
    coef_word_t      tap3_low_reg;
    coef_byte_t      tap4_high_next;
    coef_byte_t      tap4_high_reg;
    coef_byte_t      rdata_next;
    coef_byte_t      rdata_reg;
    logic            hit_next;
    logic            hit_reg;

    assign page_hit = (page_select == `COEF_BANK_PAGE);
    assign wr_hit   = page_hit && reg_wr;

    // Write decode: one strobe per register, only on the coefficient page
    assign wr_sel[IDX_NUMER3_LOW]  = wr_hit && (reg_addr == `OFS_NUMER3_LOW);
    assign wr_sel[IDX_NUMER4_HIGH] = wr_hit && (reg_addr == `OFS_NUMER4_HIGH);
    assign wr_sel[IDX_NUMER4_LOW]  = wr_hit && (reg_addr == `OFS_NUMER4_LOW);
    assign wr_sel[IDX_NUMER5_HIGH] = wr_hit && (reg_addr == `OFS_NUMER5_HIGH);
    assign wr_sel[IDX_NUMER5_LOW]  = wr_hit && (reg_addr == `OFS_NUMER5_LOW);
    assign wr_sel[IDX_DENOM1_HIGH] = wr_hit && (reg_addr == `OFS_DENOM1_HIGH);
    assign wr_sel[IDX_DENOM1_LOW]  = wr_hit && (reg_addr == `OFS_DENOM1_LOW);
    assign wr_sel[IDX_DENOM2_HIGH] = wr_hit && (reg_addr == `OFS_DENOM2_HIGH);
    assign wr_sel[IDX_DENOM2_LOW]  = wr_hit && (reg_addr == `OFS_DENOM2_LOW);
    assign wr_sel[IDX_DENOM4_HIGH] = wr_hit && (reg_addr == `OFS_DENOM4_HIGH);

    // Byte registers, each with its own reset value
    coef_byte_reg #(
        .RESET_VALUE (`RST_NUMER3_LOW)
    ) u_numer3_low (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_NUMER3_LOW]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_NUMER3_LOW])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_NUMER4_HIGH)
    ) u_numer4_high (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_NUMER4_HIGH]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_NUMER4_HIGH])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_NUMER4_LOW)
    ) u_numer4_low (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_NUMER4_LOW]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_NUMER4_LOW])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_NUMER5_HIGH)
    ) u_numer5_high (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_NUMER5_HIGH]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_NUMER5_HIGH])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_NUMER5_LOW)
    ) u_numer5_low (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_NUMER5_LOW]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_NUMER5_LOW])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_DENOM1_HIGH)
    ) u_denom1_high (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_DENOM1_HIGH]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_DENOM1_HIGH])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_DENOM1_LOW)
    ) u_denom1_low (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_DENOM1_LOW]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_DENOM1_LOW])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_DENOM2_HIGH)
    ) u_denom2_high (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_DENOM2_HIGH]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_DENOM2_HIGH])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_DENOM2_LOW)
    ) u_denom2_low (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_DENOM2_LOW]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_DENOM2_LOW])
    );

    coef_byte_reg #(
        .RESET_VALUE (`RST_DENOM4_HIGH)
    ) u_denom4_high (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_sel[IDX_DENOM4_HIGH]),
        .wr_data (reg_wdata),
        .value   (byte_val[IDX_DENOM4_HIGH])
    );

    // Low byte of tap three pairs with a high byte held outside this bank
    always_comb begin
        tap3_low_next = tap3_low_reg;
        if (wr_sel[IDX_NUMER3_LOW]) begin
            tap3_low_next = {8'h00, reg_wdata};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tap3_low_reg <= {8'h00, `RST_NUMER3_LOW};
        end else begin
            tap3_low_reg <= tap3_low_next;
        end
    end

    // Tap four low byte lives in the next bank, so only the high byte is exported
    always_comb begin
        tap4_high_next = tap4_high_reg;
        if (wr_sel[IDX_DENOM4_HIGH]) begin
            tap4_high_next = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tap4_high_reg <= `RST_DENOM4_HIGH;
        end else begin
            tap4_high_reg <= tap4_high_next;
        end
    end

    // Committed words: the high byte waits until its low byte arrives
    coef_pair_commit #(
        .RESET_WORD (RST_WORD_NUMER4)
    ) u_numer4 (
        .clk       (clk),
        .rst       (rst),
        .low_wr    (wr_sel[IDX_NUMER4_LOW]),
        .high_byte (byte_val[IDX_NUMER4_HIGH]),
        .low_data  (reg_wdata),
        .word      (numerator_tap_four)
    );

    coef_pair_commit #(
        .RESET_WORD (RST_WORD_NUMER5)
    ) u_numer5 (
        .clk       (clk),
        .rst       (rst),
        .low_wr    (wr_sel[IDX_NUMER5_LOW]),
        .high_byte (byte_val[IDX_NUMER5_HIGH]),
        .low_data  (reg_wdata),
        .word      (numerator_tap_five)
    );

    coef_pair_commit #(
        .RESET_WORD (RST_WORD_DENOM1)
    ) u_denom1 (
        .clk       (clk),
        .rst       (rst),
        .low_wr    (wr_sel[IDX_DENOM1_LOW]),
        .high_byte (byte_val[IDX_DENOM1_HIGH]),
        .low_data  (reg_wdata),
        .word      (denominator_tap_one)
    );

    coef_pair_commit #(
        .RESET_WORD (RST_WORD_DENOM2)
    ) u_denom2 (
        .clk       (clk),
        .rst       (rst),
        .low_wr    (wr_sel[IDX_DENOM2_LOW]),
        .high_byte (byte_val[IDX_DENOM2_HIGH]),
        .low_data  (reg_wdata),
        .word      (denominator_tap_two)
    );

    // Read data registered; unmapped or other-page reads return zero
    always_comb begin
        rdata_next = rdata_reg;
        hit_next   = 1'b0;
        if (reg_rd) begin
            rdata_next = 8'h00;
            if (page_hit) begin
                hit_next = 1'b1;
                unique case (reg_addr)
                    `OFS_NUMER3_LOW:  rdata_next = byte_val[IDX_NUMER3_LOW];
                    `OFS_NUMER4_HIGH: rdata_next = byte_val[IDX_NUMER4_HIGH];
                    `OFS_NUMER4_LOW:  rdata_next = byte_val[IDX_NUMER4_LOW];
                    `OFS_NUMER5_HIGH: rdata_next = byte_val[IDX_NUMER5_HIGH];
                    `OFS_NUMER5_LOW:  rdata_next = byte_val[IDX_NUMER5_LOW];
                    `OFS_DENOM1_HIGH: rdata_next = byte_val[IDX_DENOM1_HIGH];
                    `OFS_DENOM1_LOW:  rdata_next = byte_val[IDX_DENOM1_LOW];
                    `OFS_DENOM2_HIGH: rdata_next = byte_val[IDX_DENOM2_HIGH];
                    `OFS_DENOM2_LOW:  rdata_next = byte_val[IDX_DENOM2_LOW];
                    `OFS_DENOM4_HIGH: rdata_next = byte_val[IDX_DENOM4_HIGH];
                    default: begin
                        rdata_next = 8'h00;
                        hit_next   = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            hit_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg   <= hit_next;
        end
    end

    assign numerator_tap_three_low   = tap3_low_reg;
    assign denominator_tap_four_high = tap4_high_reg;
    assign reg_rdata                 = rdata_reg;
    assign reg_hit                   = hit_reg;
endmodule

// >>> shared/effects_coef_regs.svh
// Purpose: Offsets, reset values and widths for the left effects coefficient bank
// Assumes: Page one of the control register space, byte-wide registers
// Notes:   Offsets are page-relative register numbers
`ifndef EFFECTS_COEF_REGS_SVH
`define EFFECTS_COEF_REGS_SVH

`define COEF_BYTE_W          8
`define COEF_ADDR_W          7
`define COEF_WORD_W          16
`define COEF_BANK_PAGE       1'h1

`define OFS_NUMER3_LOW       7'h08
`define OFS_NUMER4_HIGH      7'h09
`define OFS_NUMER4_LOW       7'h0A
`define OFS_NUMER5_HIGH      7'h0B
`define OFS_NUMER5_LOW       7'h0C
`define OFS_DENOM1_HIGH      7'h0D
`define OFS_DENOM1_LOW       7'h0E
`define OFS_DENOM2_HIGH      7'h0F
`define OFS_DENOM2_LOW       7'h10
`define OFS_DENOM4_HIGH      7'h11

`define RST_NUMER3_LOW       8'hE3
`define RST_NUMER4_HIGH      8'h96
`define RST_NUMER4_LOW       8'h66
`define RST_NUMER5_HIGH      8'h67
`define RST_NUMER5_LOW       8'h5D
`define RST_DENOM1_HIGH      8'h7D
`define RST_DENOM1_LOW       8'h83
`define RST_DENOM2_HIGH      8'h84
`define RST_DENOM2_LOW       8'hEE
`define RST_DENOM4_HIGH      8'h7D

`endif

// >>> shared/effects_coef_pkg.sv
// Purpose: Types shared by the left effects coefficient bank
// Assumes: Constants come from effects_coef_regs.svh
// Notes:   Coefficients are signed 16-bit words
package effects_coef_pkg;
    typedef logic [7:0]         coef_byte_t;
    typedef logic signed [15:0] coef_word_t;
endpackage

// >>> hw/coef_byte_reg.sv
// Purpose: One read/write coefficient byte with its own reset value
// Assumes: Synchronous active-high reset
// Notes:   Used once per register of the bank
`timescale 1ns/100ps
`include "effects_coef_regs.svh"
module coef_byte_reg
    import effects_coef_pkg::*;
#(
    parameter coef_byte_t RESET_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Write side
    input  wire logic       wr_en,
    input  wire coef_byte_t wr_data,
    // Stored value
    output coef_byte_t      value
);
    coef_byte_t value_reg;
    coef_byte_t value_next;

    always_comb begin
        value_next = value_reg;
        if (wr_en) begin
            value_next = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule

// >>> hw/coef_pair_commit.sv
// Purpose: Holds the 16-bit word handed to the filter for one coefficient
// Assumes: High byte is written before the low byte
// Notes:   Word only moves on a low-byte write, never on a high-byte write
`timescale 1ns/100ps
`include "effects_coef_regs.svh"
module coef_pair_commit
    import effects_coef_pkg::*;
#(
    parameter coef_word_t RESET_WORD = 16'h0000
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register side
    input  wire logic       low_wr,
    input  wire coef_byte_t high_byte,
    input  wire coef_byte_t low_data,
    // Filter side
    output coef_word_t      word
);
    coef_word_t word_reg;
    coef_word_t word_next;

    always_comb begin
        word_next = word_reg;
        if (low_wr) begin
            word_next = {high_byte, low_data};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            word_reg <= RESET_WORD;
        end else begin
            word_reg <= word_next;
        end
    end

    assign word = word_reg;
endmodule

// >>> dv/coef_regs_sva.sv
// Purpose: Port assertions for the left effects coefficient bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
`include "effects_coef_regs.svh"
module coef_regs_sva
    import effects_coef_pkg::*;
(
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rst,
    // Control bus
    input wire logic                    page_select,
    input wire logic [`COEF_ADDR_W-1:0] reg_addr,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire coef_byte_t              reg_wdata,
    input wire coef_byte_t              reg_rdata,
    input wire logic                    reg_hit,
    // Filter words
    input wire coef_word_t              numerator_tap_three_low,
    input wire coef_word_t              numerator_tap_four,
    input wire coef_word_t              numerator_tap_five,
    input wire coef_word_t              denominator_tap_one,
    input wire coef_word_t              denominator_tap_two,
    input wire coef_byte_t              denominator_tap_four_high
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic       hit;
    coef_byte_t n4_high;
    assign hit = page_select && reg_addr >= 7'h08 && reg_addr <= 7'h11;

    // Last high byte written for tap four: the half that waits for the low byte
    always_ff @(posedge clk) begin
        if (rst) begin
            n4_high <= `RST_NUMER4_HIGH;
        end else if (reg_wr && hit && reg_addr == `OFS_NUMER4_HIGH) begin
            n4_high <= reg_wdata;
        end
    end
    AST_RD_HIT: assert property (reg_rd && hit |=> reg_hit) else $error("hit missing");
    AST_RD_MISS: assert property (reg_rd && !hit |=> !reg_hit && reg_rdata == 8'h00)
        else $error("miss answered");
    AST_NO_RD: assert property (!reg_rd |=> !reg_hit && $stable(reg_rdata)) else $error("read data moved");
    AST_WR_N3: assert property (reg_wr && hit && reg_addr == 7'h08 |=>
        numerator_tap_three_low == {8'h00, $past(reg_wdata)}) else $error("tap three low wrong");
    AST_WR_D4: assert property (reg_wr && hit && reg_addr == 7'h11 |=>
        denominator_tap_four_high == $past(reg_wdata)) else $error("tap four high wrong");
    AST_N4_COMMIT: assert property (reg_wr && hit && reg_addr == 7'h0A |=>
        numerator_tap_four == {$past(n4_high), $past(reg_wdata)}) else $error("word not committed");
    AST_N4_HOLD: assert property (!(reg_wr && hit && reg_addr == 7'h0A) |=> $stable(numerator_tap_four))
        else $error("word moved early");
    AST_D1_HOLD: assert property (!(reg_wr && hit && reg_addr == 7'h0E) |=> $stable(denominator_tap_one))
        else $error("word moved early");
    AST_RST_VAL: assert property ($fell(rst) |-> numerator_tap_four == 16'h9666
        && numerator_tap_five == 16'h675D && numerator_tap_three_low == 16'h00E3
        && denominator_tap_one == 16'h7D83 && denominator_tap_two == 16'h84EE && denominator_tap_four_high == 8'h7D)
        else $error("reset words wrong");
    cover property (reg_rd && hit ##1 reg_hit);
    cover property (reg_wr && hit && reg_addr == 7'h0A);
    cover property (reg_rd && !page_select);
endmodule

// >>> dv/left_effects_filter_coef_regs_tb.sv
// Purpose: Self-checking bench for the left effects coefficient bank
// Assumes: Reads answer one cycle after the strobe
// Notes:   Read results are queued by the driver and checked by a monitor
`timescale 1ns/100ps
`include "effects_coef_regs.svh"
module left_effects_filter_coef_regs_tb import effects_coef_pkg::*;;
    logic       clk = 1'b0, rst = 1'b1, page_select = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    coef_byte_t reg_wdata = 8'h00, reg_rdata, wd4;
    logic       reg_hit;
    coef_word_t w3, w4, w5, wd1, wd2;
    coef_byte_t mem [10];
    logic [15:0] ew [6];
    logic [8:0] q [$];
    int         n_mismatch = 0, samples_checked = 0;

    left_effects_filter_coef_regs i_dut (.clk(clk), .rst(rst), .page_select(page_select), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .numerator_tap_three_low(w3), .numerator_tap_four(w4), .numerator_tap_five(w5),
        .denominator_tap_one(wd1), .denominator_tap_two(wd2), .denominator_tap_four_high(wd4));

    initial forever #2 clk = ~clk;

    task wrap_up;
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk_rd(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task chk_w(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function void init;
        mem = '{8'hE3, 8'h96, 8'h66, 8'h67, 8'h5D, 8'h7D, 8'h83, 8'h84, 8'hEE, 8'h7D};
        ew = '{16'h00E3, 16'h9666, 16'h675D, 16'h7D83, 16'h84EE, 16'h007D};
    endfunction

    // One bus cycle; the model follows the write so a later read sees it
    task op(input logic w, input logic r, input logic p, input logic [6:0] a, input coef_byte_t d);
        int   i;
        logic h;
        i = int'(a) - 8;
        h = p && a >= 7'h08 && a <= 7'h11;
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= r;
        page_select <= p;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) q.push_back(h ? {1'b1, mem[i]} : 9'h000);
        if (w && h) begin
            mem[i] = d;
            if (i == 0 || i == 9) ew[i == 0 ? 0 : 5] = {8'h00, d};
            else if (i % 2 == 0) ew[i / 2] = {mem[i - 1], d};
        end
    endtask

    task idle_chk;
        op(1'b0, 1'b0, 1'b1, 7'h00, 8'h00);
        @(posedge clk);
        chk_w({w3, w4, w5, wd1, wd2, 8'h00, wd4}, {ew[0], ew[1], ew[2], ew[3], ew[4], ew[5]});
    endtask

    // Ascending offsets put each paired high byte just before its low byte
    task sweep(input logic w);
        for (int i = 0; i < 10; i++) op(w, !w, 1'b1, 7'(8 + i), 8'($urandom));
        idle_chk();
    endtask

    always @(posedge clk) begin
        if (rd_seen) chk_rd({reg_hit, reg_rdata}, q.pop_front());
        rd_seen <= reg_rd;
    end

    initial begin
        init();
        void'($urandom(32'h843e));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            sweep(1'b0);
            sweep(1'b1);
            sweep(1'b0);
            op(1'b1, 1'b0, 1'b1, 7'h09, 8'($urandom));
            op(1'b0, 1'b1, 1'b1, 7'h09, 8'h00);
            op(1'b1, 1'b0, 1'b0, 7'h0A, 8'($urandom));
            op(1'b0, 1'b1, 1'b0, 7'h0A, 8'h00);
            op(1'b1, 1'b0, 1'b1, 7'h07, 8'($urandom));
            op(1'b0, 1'b1, 1'b1, 7'h12, 8'h00);
            op(1'b0, 1'b1, 1'b1, 7'h0A, 8'h00);
            idle_chk();
            // Mid-run reset must bring every byte and word back
            rst <= 1'b1;
            repeat (6) @(posedge clk);
            rst <= 1'b0;
            init();
        end
        sweep(1'b0);
        // Let the last read answer reach the monitor before the verdict
        repeat (2) @(posedge clk);
        chk_w(96'(q.size()), 96'h0);
        wrap_up();
    end

    initial begin
        #3000;
        n_mismatch++;
        wrap_up();
    end
endmodule

bind left_effects_filter_coef_regs coef_regs_sva i_sva (.clk(clk), .rst(rst), .page_select(page_select),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .numerator_tap_three_low(numerator_tap_three_low), .numerator_tap_four(numerator_tap_four),
    .numerator_tap_five(numerator_tap_five), .denominator_tap_one(denominator_tap_one),
    .denominator_tap_two(denominator_tap_two), .denominator_tap_four_high(denominator_tap_four_high));
